// File: irq_enable_pending_eoi.sv
// enable, pending and end-of-service logic of a vectored interrupt controller with an APB slave
// assumes APB master and all request inputs synchronous to i_ref_clk; per-channel priorities come in on a port
//
// Functional notes
// - fast channel answers only when enabled
// - hardware sets fast pending on enabled request
// - fast pending cleared only by writing one
// - disabled channel never sets its pending bit
// - one enable bit per normal channel
// - lower pending bit marks unserviced enabled request
// - normal pending bits cleared by writing one
// - clearing serviced pending bit ends service, pops
// - request line holds after pending cleared early
// - request drops on vector read, soft reset, disable
// - early clear after vector read still ends service
// - disabled requests freeze stack; pop is lost
// - fast, enable and pending registers reset zero
// - upper pending register for channels 32 to 63
// - request only above current priority; zero never
// - vector read starts service, updates current priority
//
// The implementer's own choice: register access over APB.
`timescale 1ns/1ps
`include "irq_map.svh"
module irq_enable_pending_eoi
  import irq_pkg::*;
#(
  parameter int NUM_CHAN = `NUM_CHAN,
  parameter int STACK_DEPTH = `STACK_DEPTH
) (
  // clock and reset
  input wire logic i_ref_clk,
  input wire logic i_reset,
  // APB slave
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [7:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  // interrupt sources
  input wire logic [NUM_CHAN-1:0] i_irq_req,
  input wire logic [`NUM_FAST-1:0] i_fast_req,
  input wire logic [NUM_CHAN*`PRIO_W-1:0] i_source_priority,
  // processor side
  output logic o_cpu_request_n,
  output logic o_fast_request_n,
  output logic [`PRIO_W-1:0] o_current_priority
);
  localparam int SP_W = $clog2(STACK_DEPTH) + 1;
  localparam int ENT_W = `CHAN_W + `PRIO_W;
  localparam logic [SP_W-1:0] SP_FULL = SP_W'(STACK_DEPTH);

  // software-visible state
  logic [2:0] ctrl_reg;
  logic [1:0] fast_enable_reg;
  logic [31:0] enable_low_reg;
  logic [31:0] enable_high_reg;
  logic [15:0] vector_high_reg;
  logic [`NUM_FAST-1:0] fast_pending;
  logic [NUM_CHAN-1:0] channel_pending;
  logic [NUM_CHAN-1:0] channel_enable;

  // service state
  ctl_state_t state_reg;
  prio_t cur_prio_reg;
  chan_t served_chan_reg;
  logic [SP_W-1:0] sp_reg;
  logic [ENT_W-1:0] stack_rdata;

  // bus decode
  logic acc;
  logic wr;
  logic rd;
  logic mapped;
  logic [31:0] rd_value;
  logic vec_rd;
  logic soft_rst;
  logic irq_en;
  logic [NUM_CHAN-1:0] pend_clear;
  logic [`NUM_FAST-1:0] fast_clear;
  logic eoi;
  logic push;
  logic pop;
  prio_t best_prio;
  chan_t best_chan;
  logic cand_valid;

  // pready is raised one cycle into the access phase, so every transfer has one wait state
  assign acc = i_psel && i_penable && o_pready;
  assign wr = acc && i_pwrite;
  assign rd = acc && !i_pwrite;
  assign irq_en = ctrl_reg[`CTRL_IRQ_EN];
  assign soft_rst = ctrl_reg[`CTRL_SOFT_RST];
  assign vec_rd = rd && (i_paddr == `OFS_VECTOR);
  assign channel_enable = {enable_high_reg, enable_low_reg};

  always_comb begin
    mapped = 1'b1;
    rd_value = `REG_RESET;
    if (i_paddr == `OFS_CTRL) begin
      rd_value[1:0] = ctrl_reg[1:0];
    end else if (i_paddr == `OFS_CUR_PRIO) begin
      rd_value[`PRIO_W-1:0] = cur_prio_reg;
    end else if (i_paddr == `OFS_VECTOR) begin
      rd_value = {vector_high_reg, 10'h000, best_chan};
    end else if (i_paddr == `OFS_FAST_CTRL) begin
      rd_value[`FAST_PEND_LSB+1:`FAST_PEND_LSB] = fast_pending;
      rd_value[`FAST_EN_LSB+1:`FAST_EN_LSB] = fast_enable_reg;
    end else if (i_paddr == `OFS_EN_LOW) begin
      rd_value = enable_low_reg;
    end else if (i_paddr == `OFS_EN_HIGH) begin
      rd_value = enable_high_reg;
    end else if (i_paddr == `OFS_PEND_LOW) begin
      rd_value = channel_pending[31:0];
    end else if (i_paddr == `OFS_PEND_HIGH) begin
      rd_value = channel_pending[63:32];
    end else begin
      mapped = 1'b0;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      o_pready <= 1'b0;
      o_prdata <= `REG_RESET;
      o_pslverr <= 1'b0;
    end else begin
      o_pready <= i_psel && i_penable && !o_pready;
      if (i_psel && i_penable && !o_pready) begin
        o_prdata <= i_pwrite ? `REG_RESET : rd_value;
        o_pslverr <= !mapped;
      end
    end
  end

  // soft reset bit is a one-cycle pulse; it never reads back as one
  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      ctrl_reg <= 3'h0;
    end else if (wr && i_paddr == `OFS_CTRL) begin
      ctrl_reg <= i_pwdata[2:0];
    end else begin
      ctrl_reg[`CTRL_SOFT_RST] <= 1'b0;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      fast_enable_reg <= 2'h0;
      enable_low_reg <= `REG_RESET;
      enable_high_reg <= `REG_RESET;
      vector_high_reg <= 16'h0000;
    end else if (wr) begin
      if (i_paddr == `OFS_FAST_CTRL) begin
        fast_enable_reg <= i_pwdata[`FAST_EN_LSB+1:`FAST_EN_LSB];
      end else if (i_paddr == `OFS_EN_LOW) begin
        enable_low_reg <= i_pwdata;
      end else if (i_paddr == `OFS_EN_HIGH) begin
        enable_high_reg <= i_pwdata;
      end else if (i_paddr == `OFS_VECTOR) begin
        vector_high_reg <= i_pwdata[31:16];
      end
    end
  end

  assign fast_clear = (wr && i_paddr == `OFS_FAST_CTRL) ? i_pwdata[`FAST_PEND_LSB+1:`FAST_PEND_LSB] : 2'h0;
  assign pend_clear[31:0] = (wr && i_paddr == `OFS_PEND_LOW) ? i_pwdata : 32'h00000000;
  assign pend_clear[63:32] = (wr && i_paddr == `OFS_PEND_HIGH) ? i_pwdata : 32'h00000000;

  pending_bank #(.WIDTH(`NUM_FAST)) u_fast_pending (
    .i_ref_clk(i_ref_clk),
    .i_reset(i_reset),
    .i_req(i_fast_req),
    .i_enable(fast_enable_reg),
    .i_clear(fast_clear),
    .o_pending(fast_pending)
  );

  pending_bank #(.WIDTH(NUM_CHAN)) u_chan_pending (
    .i_ref_clk(i_ref_clk),
    .i_reset(i_reset),
    .i_req(i_irq_req),
    .i_enable(channel_enable),
    .i_clear(pend_clear),
    .o_pending(channel_pending)
  );

  // fast line follows enabled pending bits; software gates it with the fast enable in control
  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      o_fast_request_n <= 1'b1;
    end else begin
      o_fast_request_n <= !(ctrl_reg[`CTRL_FIQ_EN] && |(fast_pending & fast_enable_reg));
    end
  end

  // highest priority enabled pending channel; ties go to the lower channel number
  always_comb begin
    best_prio = '0;
    best_chan = '0;
    for (int i = 0; i < NUM_CHAN; i++) begin
      if (channel_pending[i] && channel_enable[i] && i_source_priority[i*`PRIO_W +: `PRIO_W] > best_prio) begin
        best_prio = i_source_priority[i*`PRIO_W +: `PRIO_W];
        best_chan = chan_t'(i);
      end
    end
  end
  // priority zero can never exceed the current priority
  assign cand_valid = best_prio > cur_prio_reg;

  // end of service: a write of one onto the pending bit of the channel being served
  assign eoi = (sp_reg != '0) && pend_clear[served_chan_reg];
  assign pop = eoi && irq_en && !soft_rst; // frozen stack drops the pop for good
  assign push = vec_rd && state_reg == ST_WAIT && cand_valid && sp_reg != SP_FULL && !soft_rst;

  always_ff @(posedge i_ref_clk) begin
    if (i_reset || soft_rst) begin
      state_reg <= ST_IDLE;
      o_cpu_request_n <= 1'b1;
    end else begin
      case (state_reg)
        ST_IDLE: begin
          if (irq_en && cand_valid) begin
            state_reg <= ST_WAIT;
            o_cpu_request_n <= 1'b0;
          end
        end
        ST_WAIT: begin
          // pending clears alone do not release the line
          if (vec_rd || !irq_en) begin
            state_reg <= ST_IDLE;
            o_cpu_request_n <= 1'b1;
          end
        end
        default: begin
          state_reg <= ST_IDLE;
          o_cpu_request_n <= 1'b1;
        end
      endcase
    end
  end

  stack_mem #(.DEPTH(STACK_DEPTH), .WIDTH(ENT_W), .AW(SP_W-1)) u_stack (
    .i_ref_clk(i_ref_clk),
    .i_we(push),
    .i_waddr(sp_reg[SP_W-2:0]),
    .i_wdata({served_chan_reg, cur_prio_reg}),
    .i_raddr(sp_reg[SP_W-2:0] - 1'b1),
    .o_rdata(stack_rdata)
  );

  // the stack keeps the interrupted context; the served one lives in the two registers
  always_ff @(posedge i_ref_clk) begin
    if (i_reset || soft_rst) begin
      sp_reg <= '0;
      cur_prio_reg <= '0;
      served_chan_reg <= '0;
    end else if (push) begin
      sp_reg <= sp_reg + 1'b1;
      cur_prio_reg <= best_prio;
      served_chan_reg <= best_chan;
    end else if (pop) begin
      sp_reg <= sp_reg - 1'b1;
      {served_chan_reg, cur_prio_reg} <= stack_rdata;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      o_current_priority <= '0;
    end else begin
      o_current_priority <= cur_prio_reg;
    end
  end

  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (i_reset);

  req_hold_a: assert property ((state_reg == ST_WAIT && !vec_rd && irq_en && !soft_rst) |=> !o_cpu_request_n)
    else $error("request line dropped without a release cause");
  req_drop_a: assert property ($rose(o_cpu_request_n) |-> $past(vec_rd || soft_rst || !irq_en))
    else $error("request line released without vector read, soft reset or disable");
  req_cause_a: assert property ($fell(o_cpu_request_n) |-> $past(cand_valid && irq_en))
    else $error("request raised with no channel above current priority");
  eoi_pop_a: assert property ((eoi && irq_en && !soft_rst) |=> sp_reg == $past(sp_reg) - 1'b1)
    else $error("end of service did not pop the stack");
  stack_freeze_a: assert property ((!irq_en && !soft_rst && !push) |=> $stable(sp_reg))
    else $error("stack moved while requests disabled");
  prio_update_a: assert property (push |=> cur_prio_reg == $past(best_prio) ##1 o_current_priority == cur_prio_reg)
    else $error("current priority not taken from served channel");
  fast_gate_a: assert property ($fell(o_fast_request_n) |-> $past(|(fast_pending & fast_enable_reg), 1))
    else $error("fast request raised for a disabled channel");
  reset_zero_a: assert property ($past(i_reset) |-> (channel_enable == '0 && fast_enable_reg == 2'h0 && channel_pending == '0))
    else $error("registers not zero after reset");
  apb_wait_a: assert property ((i_psel && i_penable && !o_pready) |=> o_pready ##1 !o_pready)
    else $error("apb ready not a single pulse after one wait state");

  push_c: cover property (push);
  early_clear_c: cover property (state_reg == ST_WAIT && !cand_valid && !o_cpu_request_n);
  eoi_c: cover property (pop ##[1:20] push);
  lost_pop_c: cover property (eoi && !irq_en);
endmodule

// File: irq_map.svh
// register offsets, field positions, reset values and sizes of the interrupt enable/pending block
// assumes an 8-bit APB byte address; every register is one aligned 32-bit word
`ifndef IRQ_MAP_SVH
`define IRQ_MAP_SVH

`define OFS_CTRL       8'h00
`define OFS_CUR_PRIO   8'h08
`define OFS_VECTOR     8'h18
`define OFS_FAST_CTRL  8'h1C
`define OFS_EN_LOW     8'h20
`define OFS_EN_HIGH    8'h24
`define OFS_PEND_LOW   8'h40
`define OFS_PEND_HIGH  8'h44

`define CTRL_IRQ_EN    0
`define CTRL_FIQ_EN    1
`define CTRL_SOFT_RST  2
`define FAST_EN_LSB    0
`define FAST_PEND_LSB  3

`define REG_RESET      32'h00000000
`define NUM_CHAN       64
`define NUM_FAST       2
`define PRIO_W         4
`define CHAN_W         6
`define STACK_DEPTH    16

`endif

// File: irq_pkg.sv
// types shared by the interrupt enable/pending block
// assumes nothing beyond the map header
package irq_pkg;
  typedef enum logic [0:0] {
    ST_IDLE = 1'b0,
    ST_WAIT = 1'b1
  } ctl_state_t;
  typedef logic [3:0] prio_t;
  typedef logic [5:0] chan_t;
endpackage

// File: pending_bank.sv
// bank of sticky pending bits: set by an enabled request, cleared by a write-one mask
// assumes requests and clear masks are synchronous to i_ref_clk
`timescale 1ns/1ps
module pending_bank #(
  parameter int WIDTH = 32
) (
  // clock and reset
  input wire logic i_ref_clk,
  input wire logic i_reset,
  // requests, enables and software clear mask
  input wire logic [WIDTH-1:0] i_req,
  input wire logic [WIDTH-1:0] i_enable,
  input wire logic [WIDTH-1:0] i_clear,
  // sticky pending bits
  output logic [WIDTH-1:0] o_pending
);
  genvar g;
  generate
    for (g = 0; g < WIDTH; g++) begin : g_bit
      always_ff @(posedge i_ref_clk) begin
        if (i_reset) begin
          o_pending[g] <= 1'b0;
        end else if (i_req[g] && i_enable[g]) begin
          o_pending[g] <= 1'b1; // set wins over a clear in the same cycle
        end else if (i_clear[g]) begin
          o_pending[g] <= 1'b0; // write of one clears, zero leaves it
        end
      end

      set_wins_a: assert property (@(posedge i_ref_clk) disable iff (i_reset)
        (i_req[g] && i_enable[g] && i_clear[g]) |=> o_pending[g])
        else $error("pending bit lost on simultaneous set and clear");
      clear_only_a: assert property (@(posedge i_ref_clk) disable iff (i_reset)
        ($fell(o_pending[g])) |-> $past(i_clear[g]))
        else $error("pending bit fell without a software clear");
      no_set_off_a: assert property (@(posedge i_ref_clk) disable iff (i_reset)
        ($rose(o_pending[g])) |-> $past(i_enable[g] && i_req[g]))
        else $error("pending bit set while channel disabled");
    end
  endgenerate
endmodule

// File: stack_mem.sv
// small memory holding saved {channel, priority} entries of the priority stack
// read data comes from a register, one cycle after the address
`timescale 1ns/1ps
module stack_mem #(
  parameter int DEPTH = 16,
  parameter int WIDTH = 10,
  parameter int AW = 4
) (
  // clock
  input wire logic i_ref_clk,
  // write port
  input wire logic i_we,
  input wire logic [AW-1:0] i_waddr,
  input wire logic [WIDTH-1:0] i_wdata,
  // registered read port
  input wire logic [AW-1:0] i_raddr,
  output logic [WIDTH-1:0] o_rdata
);
  logic [WIDTH-1:0] mem [DEPTH];

  always_ff @(posedge i_ref_clk) begin
    if (i_we) begin
      mem[i_waddr] <= i_wdata;
    end
  end

  // no reset on the array: entries are only read below the stack pointer
  always_ff @(posedge i_ref_clk) begin
    o_rdata <= mem[i_raddr];
  end
endmodule

// File: core_model.sv
// processor core model: apb master plus a simple interrupt service sequence
// assumes the slave raises pready to finish each access and the request line is active low
`timescale 1ns/1ps
`include "irq_map.svh"
module core_model (
  // clock
  input wire logic i_ref_clk,
  // apb master
  output logic o_psel,
  output logic o_penable,
  output logic o_pwrite,
  output logic [7:0] o_paddr,
  output logic [31:0] o_pwdata,
  input wire logic [31:0] i_prdata,
  input wire logic i_pready,
  input wire logic i_pslverr,
  // processor request line
  input wire logic i_cpu_request_n
);
  initial begin
    o_psel = 1'b0;
    o_penable = 1'b0;
    o_pwrite = 1'b0;
    o_paddr = 8'h00;
    o_pwdata = 32'h0;
  end

  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic e);
    logic [31:0] dd;
    // reserved fast bits always go out as zero
    dd = (a == `OFS_FAST_CTRL) ? (d & 32'h0000001B) : d;
    @(posedge i_ref_clk);
    o_psel <= 1'b1;
    o_penable <= 1'b0;
    o_pwrite <= wr;
    o_paddr <= a;
    o_pwdata <= dd;
    @(posedge i_ref_clk);
    o_penable <= 1'b1;
    // no cycle limit here: a slave that never answers is caught by the bench watchdog
    do begin
      @(posedge i_ref_clk);
    end while (i_pready !== 1'b1);
    q = i_prdata;
    e = i_pslverr;
    o_psel <= 1'b0;
    o_penable <= 1'b0;
    // stale data must not look valid once released
    o_pwdata <= ~dd;
  endtask

  // dly models a slow core that takes a while to fetch the vector
  task automatic service(input int dly, output logic [5:0] ch);
    logic [31:0] q;
    logic e;
    int n;
    n = 0;
    while (i_cpu_request_n !== 1'b0 && n < 32) begin
      @(posedge i_ref_clk);
      n++;
    end
    repeat (dly) @(posedge i_ref_clk);
    xfer(1'b0, `OFS_VECTOR, 32'h0, q, e);
    ch = q[5:0];
    xfer(1'b1, ch[5] ? `OFS_PEND_HIGH : `OFS_PEND_LOW, 32'h1 << ch[4:0], q, e);
  endtask
endmodule

// File: irq_enable_pending_eoi_tb_top.sv
// top bench: design, core model, random register traffic and directed interrupt flows
// assumes the map header is on the include path and the design answers every apb access
`timescale 1ns/1ps
`include "irq_map.svh"
`define CHK(nm, ex, got) \
  begin \
    n_checks++; \
    if ((got) !== (ex)) begin \
      err_count++; \
      $display("[FAIL] %s exp=%h got=%h", nm, ex, got); \
    end \
  end
module irq_enable_pending_eoi_tb_top;
  logic i_ref_clk = 1'b0;
  logic i_reset = 1'b1;
  logic psel, penable, pwrite, pready, pslverr, cpu_request_n, fast_request_n, e;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, q, en_lo, en_hi, pl, ph, m;
  logic [63:0] irq_req = 64'h0;
  logic [63:0] rq;
  logic [1:0] fast_req = 2'h0;
  // only channel 4 has a nonzero priority (7)
  logic [255:0] src_prio = 256'h70000;
  logic [3:0] cur_prio;
  logic [5:0] ch;
  logic [7:0] regs [5] = '{`OFS_FAST_CTRL, `OFS_EN_LOW, `OFS_EN_HIGH, `OFS_PEND_LOW, `OFS_PEND_HIGH};
  int err_count = 0;
  int n_checks = 0;
  integer seed = 32'hdf5dbf51;

  always #2.5 i_ref_clk = ~i_ref_clk;

  irq_enable_pending_eoi irq_enable_pending_eoi_inst (.i_ref_clk(i_ref_clk), .i_reset(i_reset),
    .i_psel(psel), .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata),
    .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr), .i_irq_req(irq_req),
    .i_fast_req(fast_req), .i_source_priority(src_prio), .o_cpu_request_n(cpu_request_n),
    .o_fast_request_n(fast_request_n), .o_current_priority(cur_prio));

  core_model core_model_inst (.i_ref_clk(i_ref_clk), .o_psel(psel), .o_penable(penable),
    .o_pwrite(pwrite), .o_paddr(paddr), .o_pwdata(pwdata), .i_prdata(prdata), .i_pready(pready),
    .i_pslverr(pslverr), .i_cpu_request_n(cpu_request_n));

  function automatic logic [31:0] exp_pend(input logic [31:0] r, input logic [31:0] en);
    return r & en;
  endfunction

  task automatic cyc(input int n);
    repeat (n) @(posedge i_ref_clk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    core_model_inst.xfer(1'b1, a, d, q, e);
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] ex);
    core_model_inst.xfer(1'b0, a, 32'h0, q, e);
    `CHK($sformatf("reg %h", a), ex, q)
  endtask

  // request high for exactly one sampling edge
  task automatic pulse_req(input logic [63:0] r);
    @(posedge i_ref_clk);
    irq_req <= r;
    @(posedge i_ref_clk);
    irq_req <= 64'h0;
  endtask

  task automatic tally_and_finish();
    $display("checks=%0d errors=%0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  initial begin
    cyc(20000);
    $display("[FAIL] watchdog expired");
    err_count++;
    tally_and_finish();
  end

  initial begin
    cyc(2);
    i_reset <= 1'b0;
    cyc(1);
    for (int i = 0; i < 5; i++) begin
      rd_chk(regs[i], 32'h0);
    end
    core_model_inst.xfer(1'b0, 8'h30, 32'h0, q, e);
    `CHK("pslverr", 1'b1, e)
    // global request enable stays off here, so clearing arbitrary pendings is safe
    for (int i = 0; i < 6; i++) begin
      en_lo = $random(seed);
      en_hi = (i == 0) ? 32'h0 : $random(seed);
      m = $random(seed);
      rq = {$random(seed), $random(seed)};
      if (i == 1) en_lo = 32'hFFFFFFFF;
      wr(`OFS_EN_LOW, en_lo);
      wr(`OFS_EN_HIGH, en_hi);
      rd_chk(`OFS_EN_LOW, en_lo);
      rd_chk(`OFS_EN_HIGH, en_hi);
      pulse_req(rq);
      pl = exp_pend(rq[31:0], en_lo);
      ph = exp_pend(rq[63:32], en_hi);
      rd_chk(`OFS_PEND_LOW, pl);
      rd_chk(`OFS_PEND_HIGH, ph);
      wr(`OFS_PEND_LOW, m);
      wr(`OFS_PEND_HIGH, ~m);
      rd_chk(`OFS_PEND_LOW, pl & ~m);
      rd_chk(`OFS_PEND_HIGH, ph & m);
      wr(`OFS_PEND_LOW, 32'hFFFFFFFF);
      wr(`OFS_PEND_HIGH, 32'hFFFFFFFF);
    end
    wr(`OFS_FAST_CTRL, 32'h1);
    wr(`OFS_CTRL, 32'h2);
    fast_req <= 2'b11;
    cyc(1);
    fast_req <= 2'b00;
    cyc(2);
    `CHK("fast_request_n", 1'b0, fast_request_n)
    rd_chk(`OFS_FAST_CTRL, 32'h9);
    wr(`OFS_FAST_CTRL, 32'h1);
    rd_chk(`OFS_FAST_CTRL, 32'h9);
    wr(`OFS_FAST_CTRL, 32'h19);
    rd_chk(`OFS_FAST_CTRL, 32'h1);
    wr(`OFS_EN_LOW, 32'h11);
    wr(`OFS_EN_HIGH, 32'h0);
    wr(`OFS_CTRL, 32'h1);
    pulse_req(64'h1);
    cyc(3);
    `CHK("cpu_request_n", 1'b1, cpu_request_n)
    pulse_req(64'h10);
    cyc(3);
    `CHK("cpu_request_n", 1'b0, cpu_request_n)
    wr(`OFS_PEND_LOW, 32'h10);
    cyc(2);
    `CHK("cpu_request_n", 1'b0, cpu_request_n)
    pulse_req(64'h10);
    core_model_inst.xfer(1'b0, `OFS_VECTOR, 32'h0, q, e);
    `CHK("vector channel", 6'd4, q[5:0])
    cyc(2);
    `CHK("cpu_request_n", 1'b1, cpu_request_n)
    `CHK("current priority", 4'h7, cur_prio)
    wr(`OFS_PEND_LOW, 32'h10);
    rd_chk(`OFS_CUR_PRIO, 32'h0);
    pulse_req(64'h10);
    cyc(3);
    wr(`OFS_CTRL, 32'h0);
    cyc(2);
    `CHK("cpu_request_n", 1'b1, cpu_request_n)
    wr(`OFS_CTRL, 32'h1);
    for (int d = 0; d < 2; d++) begin
      pulse_req(64'h10);
      core_model_inst.service(d * 5, ch);
      `CHK("served channel", 6'd4, ch)
      rd_chk(`OFS_CUR_PRIO, 32'h0);
    end
    // end of service while requests are off: the pop is lost and priority stays raised
    pulse_req(64'h10);
    core_model_inst.xfer(1'b0, `OFS_VECTOR, 32'h0, q, e);
    `CHK("vector channel", 6'd4, q[5:0])
    wr(`OFS_CTRL, 32'h0);
    wr(`OFS_PEND_LOW, 32'h10);
    wr(`OFS_CTRL, 32'h1);
    rd_chk(`OFS_CUR_PRIO, 32'h7);
    // soft reset clears the stack and priority but keeps enables; its bit reads back zero
    wr(`OFS_CTRL, 32'h5);
    rd_chk(`OFS_CUR_PRIO, 32'h0);
    rd_chk(`OFS_CTRL, 32'h1);
    rd_chk(`OFS_EN_LOW, 32'h11);
    pulse_req(64'h10);
    cyc(2);
    `CHK("cpu_request_n", 1'b0, cpu_request_n)
    // the line is released for one cycle, then the still pending channel raises it again
    wr(`OFS_CTRL, 32'h5);
    cyc(2);
    `CHK("cpu_request_n", 1'b1, cpu_request_n)
    wr(`OFS_CTRL, 32'h0);
    wr(`OFS_PEND_LOW, 32'h10);
    rd_chk(`OFS_PEND_LOW, 32'h1);
    tally_and_finish();
  end
endmodule
